// *** rtl/pin_cfg_pkg.sv ***
// Purpose: Shared constants for the pin function configuration register bank.
// Assumes: One 125 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Offsets, field positions, masks and cycle counts live here.

// ****************************************************************
// Package
// ****************************************************************
package pin_cfg_pkg;

	// Clock rate used to turn times into cycle counts.
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CLK_HZ  = CLK_MHZ * 1000000;

	// Register indices as printed; the byte address is four times the index.
	localparam logic [9:0]  CFG1_INDEX      = 10'h0a4;
	localparam logic [9:0]  CFG2_INDEX      = 10'h0a6;
	localparam logic [11:0] CFG1_ADDR       = {CFG1_INDEX, 2'b00};
	localparam logic [11:0] CFG2_ADDR       = {CFG2_INDEX, 2'b00};
	localparam logic [11:0] IRQ_STATUS_ADDR = 12'h300;
	localparam logic [11:0] IRQ_MASK_ADDR   = 12'h304;
	localparam logic [11:0] STATE_ADDR      = 12'h308;

	// Field positions of the input source and monitor register.
	localparam int MON_A_LSB = 19;
	localparam int MON_B_LSB = 7;
	localparam int STOP_LSB  = 5;
	localparam int ROT_LSB   = 3;
	localparam int SPEED_LSB = 1;

	// Field positions of the pin, sleep and watchdog register.
	localparam int SHARED_LSB  = 29;
	localparam int XTAL_BIT    = 27;
	localparam int SLEEP_LSB   = 18;
	localparam int WD_EN_BIT   = 17;
	localparam int WD_SRC_BIT  = 16;
	localparam int WD_ACT_BIT  = 15;
	localparam int WD_RATE_LSB = 13;

	// Writable bits; everything else is reserved and reads as zero.
	localparam logic [31:0] CFG1_MASK  = 32'hffff_fffe;
	localparam logic [31:0] CFG2_MASK  = 32'he80f_e000;
	localparam logic [31:0] CFG1_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG2_RESET = 32'h0000_0000;

	// Source codes of the stop and rotation fields.
	localparam logic [1:0] SRC_PIN       = 2'h0;
	localparam logic [1:0] SRC_FORCE_ON  = 2'h1;
	localparam logic [1:0] SRC_FORCE_OFF = 2'h2;

	// Interrupt status bits.
	localparam int IRQ_W         = 2;
	localparam int IRQ_WD_BIT    = 0;
	localparam int IRQ_SLEEP_BIT = 1;

	// Sleep qualification times and their cycle counts.
	localparam int unsigned SLEEP_T0_US = 50;
	localparam int unsigned SLEEP_T1_US = 200;
	localparam int unsigned SLEEP_T2_MS = 20;
	localparam int unsigned SLEEP_T3_MS = 200;
	localparam int unsigned SLEEP_CYC0  = SLEEP_T0_US * CLK_MHZ;
	localparam int unsigned SLEEP_CYC1  = SLEEP_T1_US * CLK_MHZ;
	localparam int unsigned SLEEP_CYC2  = SLEEP_T2_MS * 1000 * CLK_MHZ;
	localparam int unsigned SLEEP_CYC3  = SLEEP_T3_MS * 1000 * CLK_MHZ;

	// Watchdog tickle rates and their period counts.
	localparam int unsigned WD_F0_HZ = 10;
	localparam int unsigned WD_F1_HZ = 5;
	localparam int unsigned WD_F2_HZ = 2;
	localparam int unsigned WD_F3_HZ = 1;
	localparam int unsigned WD_CYC0  = CLK_HZ / WD_F0_HZ;
	localparam int unsigned WD_CYC1  = CLK_HZ / WD_F1_HZ;
	localparam int unsigned WD_CYC2  = CLK_HZ / WD_F2_HZ;
	localparam int unsigned WD_CYC3  = CLK_HZ / WD_F3_HZ;

endpackage

// *** rtl/cfg_timer_if.sv ***
// Purpose: Control and result signals of one qualification or watchdog timer.
// Assumes: Both ends run on the same clock.
// Notes:   The controller drives limit, run and restart; the timer answers.

`timescale 1ns/1ps

// ****************************************************************
// Interface
// ****************************************************************
interface cfg_timer_if;
	logic [31:0] limit;
	logic        run;
	logic        restart;
	logic        fire;
	logic        active;

	modport ctrl  (output limit, output run, output restart, input fire, input active);
	modport timer (input limit, input run, input restart, output fire, output active);
endinterface

// *** rtl/sleep_qualifier.sv ***
// Purpose: Declares sleep once the speed input has stayed low for the limit.
// Assumes: limit is at least one cycle.
// Notes:   active holds until run drops; fire is a one-cycle entry pulse.

`timescale 1ns/1ps

// ****************************************************************
// Sleep qualifier
// ****************************************************************
module sleep_qualifier (
	// Clock and reset.
	input wire logic  clk,
	input wire logic  rstn,
	// Timer controls.
	cfg_timer_if.timer tmr
);
	logic [31:0] count_q;
	logic        active_q;
	logic        fire_q;
	logic        reach;

	// The count only advances while the input is low and sleep is not yet taken.
	assign reach      = tmr.run && !active_q && (count_q == tmr.limit - 32'h0000_0001);
	assign tmr.fire   = fire_q;
	assign tmr.active = active_q;

	// A high input at any point restarts the qualification from zero.
	always_ff @(posedge clk) begin
		if (!rstn || !tmr.run || tmr.restart) begin
			count_q  <= 32'h0000_0000;
			active_q <= 1'b0;
			fire_q   <= 1'b0;
		end else begin
			count_q  <= active_q ? count_q : count_q + 32'h0000_0001;
			active_q <= active_q | reach;
			fire_q   <= reach;
		end
	end
endmodule // sleep_qualifier

// *** rtl/watchdog_timer.sv ***
// Purpose: Expires when no tickle comes within one configured period.
// Assumes: limit is at least one cycle; restart is a one-cycle tickle.
// Notes:   Expiry restarts the period, so a dead source expires repeatedly.

`timescale 1ns/1ps

// ****************************************************************
// Watchdog timer
// ****************************************************************
module watchdog_timer (
	// Clock and reset.
	input wire logic  clk,
	input wire logic  rstn,
	// Timer controls.
	cfg_timer_if.timer tmr
);
	logic [31:0] count_q;
	logic        fire_q;
	logic        reach;

	assign reach      = tmr.run && !tmr.restart && (count_q >= tmr.limit - 32'h0000_0001);
	assign tmr.fire   = fire_q;
	assign tmr.active = tmr.run;

	// A tickle or a disable clears the count; a tickle in the expiry cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn || !tmr.run || tmr.restart || reach) begin
			count_q <= 32'h0000_0000;
		end else begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fire_q <= 1'b0;
		end else begin
			fire_q <= reach;
		end
	end
endmodule // watchdog_timer

// *** rtl/pin_function_config_regs.sv ***
// Purpose: Pin function, sleep and external watchdog configuration registers.
// Assumes: AXI4-Lite master, pins already synchronous to clk.
// Notes:   All outputs are registered, so they follow register writes one cycle late.
//
// Function
// - Two 12-bit monitor variable addresses sit at bits 30-19 and 18-7 and reset to zero.
// - The stop source code follows the pin at 0, forces braking at 1, forbids it at 2.
// - The rotation source code follows the pin at 0 and forces clockwise order at 1.
// - The speed command source picks analog, PWM duty, serial bus or frequency input.
// - The shared pin code routes monitor B or the phase A, B or C current sense output.
// - The crystal pin bit, when set, puts monitor A and monitor B on the crystal pins.
// - Sleep is entered after the speed input stays low for 50 us, 200 us, 20 ms or 200 ms.
// - The external watchdog is supervised only while its enable bit is set.
// - The watchdog tickle comes from the serial bus at 0 and the input pin at 1.
// - On expiry the fault is only reported at 0, or latched with outputs floated at 1.
// - The tickle rate is 10, 5, 2 or 1 Hz and the far side must tickle at least that fast.
//
// Our own choice: the AXI4-Lite slave port.

`timescale 1ns/1ps

// ****************************************************************
// Top module
// ****************************************************************
module pin_function_config_regs #(
	parameter int unsigned SLEEP_CYC_0 = pin_cfg_pkg::SLEEP_CYC0,
	parameter int unsigned SLEEP_CYC_1 = pin_cfg_pkg::SLEEP_CYC1,
	parameter int unsigned SLEEP_CYC_2 = pin_cfg_pkg::SLEEP_CYC2,
	parameter int unsigned SLEEP_CYC_3 = pin_cfg_pkg::SLEEP_CYC3,
	parameter int unsigned WD_CYC_0    = pin_cfg_pkg::WD_CYC0,
	parameter int unsigned WD_CYC_1    = pin_cfg_pkg::WD_CYC1,
	parameter int unsigned WD_CYC_2    = pin_cfg_pkg::WD_CYC2,
	parameter int unsigned WD_CYC_3    = pin_cfg_pkg::WD_CYC3
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address and data.
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pin and bus inputs.
	input  wire logic        brake_pin,
	input  wire logic        direction_pin,
	input  wire logic        speed_input_low,
	input  wire logic        i2c_tickle,
	input  wire logic        gpio_tickle_pin,
	// Configuration outputs.
	output logic [11:0]      monitor_a_variable_address,
	output logic [11:0]      monitor_b_variable_address,
	output logic             brake_active,
	output logic             direction_cw,
	output logic [1:0]       speed_command_source,
	output logic [1:0]       shared_pin_route,
	output logic             crystal_pin_repurpose,
	// Sleep, watchdog and interrupt outputs.
	output logic             sleep_request,
	output logic             motor_outputs_hiz,
	output logic             watchdog_fault,
	output logic             irq
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// One-hot register select: cfg1, cfg2, status, mask, state.
	function automatic logic [4:0] reg_sel(input logic [11:0] addr);
		reg_sel = {addr == pin_cfg_pkg::STATE_ADDR,
			addr == pin_cfg_pkg::IRQ_MASK_ADDR,
			addr == pin_cfg_pkg::IRQ_STATUS_ADDR,
			addr == pin_cfg_pkg::CFG2_ADDR,
			addr == pin_cfg_pkg::CFG1_ADDR};
	endfunction

	// Byte lane merge of a write into an old value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (data & m);
	endfunction

	// ****************************************************************
	// Bus write channel
	// ****************************************************************
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        aw_take;
	logic        w_take;
	logic        wr_fire;
	logic        aw_held_d;
	logic        w_held_d;
	logic [4:0]  wr_sel;
	logic        wr_mapped;

	// Address and data are taken independently; the write happens once both are held.
	assign aw_take   = s_axi_awvalid && awready_q;
	assign w_take    = s_axi_wvalid && wready_q;
	assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
	assign aw_held_d = (aw_held_q || aw_take) && !wr_fire;
	assign w_held_d  = (w_held_q || w_take) && !wr_fire;
	assign wr_sel    = wr_fire ? reg_sel(aw_addr_q) : 5'h00;
	assign wr_mapped = |reg_sel(aw_addr_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awready_q <= !aw_held_d;
			wready_q  <= !w_held_d;
		end
	end

	// Payloads are captured without reset; they are only used once held.
	always_ff @(posedge clk) begin
		if (aw_take) begin
			aw_addr_q <= s_axi_awaddr;
		end
		if (w_take) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	// Unmapped addresses answer SLVERR and change nothing.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= 2'b00;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	localparam int IRQ_W_C = pin_cfg_pkg::IRQ_W;
	logic [31:0]          cfg1_q;
	logic [31:0]          cfg2_q;
	logic [IRQ_W_C-1:0]   stat_q;
	logic [IRQ_W_C-1:0]   mask_q;
	logic [IRQ_W_C-1:0]   events;
	logic [IRQ_W_C-1:0]   w1c;
	logic                 fault_latch_q;

	// Reserved bits are masked on every write so they always read zero.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg1_q <= pin_cfg_pkg::CFG1_RESET;
			cfg2_q <= pin_cfg_pkg::CFG2_RESET;
			mask_q <= '0;
		end else begin
			if (wr_sel[0]) begin
				cfg1_q <= merge(cfg1_q, w_data_q, w_strb_q) & pin_cfg_pkg::CFG1_MASK;
			end
			if (wr_sel[1]) begin
				cfg2_q <= merge(cfg2_q, w_data_q, w_strb_q) & pin_cfg_pkg::CFG2_MASK;
			end
			if (wr_sel[3] && w_strb_q[0]) begin
				mask_q <= w_data_q[IRQ_W_C-1:0];
			end
		end
	end

	// Status bits are write-one-to-clear; a new event in the clear cycle wins.
	assign w1c = (wr_sel[2] && w_strb_q[0]) ? w_data_q[IRQ_W_C-1:0] : '0;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~w1c) | events;
		end
	end

	// ****************************************************************
	// Bus read channel
	// ****************************************************************
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        ar_take;
	logic        rvalid_d;
	logic [4:0]  rd_sel;
	logic [31:0] rd_word;
	logic [31:0] state_word;

	// Timer links are declared here because the state word reads them.
	cfg_timer_if sleep_tmr ();
	cfg_timer_if wd_tmr ();

	assign ar_take    = s_axi_arvalid && arready_q;
	assign rvalid_d   = (rvalid_q && !s_axi_rready) || ar_take;
	assign rd_sel     = reg_sel(s_axi_araddr);
	assign state_word = {29'h0000_0000, sleep_tmr.active, fault_latch_q, wd_tmr.active};
	assign rd_word    = ({32{rd_sel[0]}} & cfg1_q)
		| ({32{rd_sel[1]}} & cfg2_q)
		| ({32{rd_sel[2]}} & {30'h0000_0000, stat_q})
		| ({32{rd_sel[3]}} & {30'h0000_0000, mask_q})
		| ({32{rd_sel[4]}} & state_word);

	// Data is sampled when the address is taken and held until rready.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= 2'b00;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= (|rd_sel) ? 2'b00 : 2'b10;
			end
		end
	end

	// ****************************************************************
	// Sleep and watchdog timers
	// ****************************************************************
	logic        gpio_prev_q;
	logic        tickle;
	logic [1:0]  sleep_code;
	logic [1:0]  rate_code;

	assign sleep_code = cfg2_q[pin_cfg_pkg::SLEEP_LSB +: 2];
	assign rate_code  = cfg2_q[pin_cfg_pkg::WD_RATE_LSB +: 2];

	// Sleep qualification length by code.
	assign sleep_tmr.limit   = (sleep_code == 2'h0) ? 32'(SLEEP_CYC_0) :
		(sleep_code == 2'h1) ? 32'(SLEEP_CYC_1) :
		(sleep_code == 2'h2) ? 32'(SLEEP_CYC_2) : 32'(SLEEP_CYC_3);
	assign sleep_tmr.run     = speed_input_low;
	assign sleep_tmr.restart = 1'b0;

	// Tickle source select; the pin counts on its rising edge only.
	assign tickle = cfg2_q[pin_cfg_pkg::WD_SRC_BIT] ? (gpio_tickle_pin && !gpio_prev_q)
		: i2c_tickle;

	// One watchdog period per rate code.
	assign wd_tmr.limit   = (rate_code == 2'h0) ? 32'(WD_CYC_0) :
		(rate_code == 2'h1) ? 32'(WD_CYC_1) :
		(rate_code == 2'h2) ? 32'(WD_CYC_2) : 32'(WD_CYC_3);
	assign wd_tmr.run     = cfg2_q[pin_cfg_pkg::WD_EN_BIT];
	assign wd_tmr.restart = tickle;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			gpio_prev_q <= 1'b0;
		end else begin
			gpio_prev_q <= gpio_tickle_pin;
		end
	end

	sleep_qualifier u_sleep (
		.clk  (clk),
		.rstn (rstn),
		.tmr  (sleep_tmr)
	);

	watchdog_timer u_wd (
		.clk  (clk),
		.rstn (rstn),
		.tmr  (wd_tmr)
	);

	assign events = {sleep_tmr.fire, wd_tmr.fire && wd_tmr.run};

	// Latched fault holds until software clears the watchdog status bit.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fault_latch_q <= 1'b0;
		end else if (events[0] && cfg2_q[pin_cfg_pkg::WD_ACT_BIT]) begin
			fault_latch_q <= 1'b1;
		end else if (w1c[0]) begin
			fault_latch_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Output registers
	// ****************************************************************
	logic [1:0] stop_code;
	logic [1:0] rot_code;
	logic       brake_d;
	logic       dir_d;

	assign stop_code = cfg1_q[pin_cfg_pkg::STOP_LSB +: 2];
	assign rot_code  = cfg1_q[pin_cfg_pkg::ROT_LSB +: 2];
	// Undefined codes fall back to the pin, the safest guess.
	assign brake_d   = (stop_code == pin_cfg_pkg::SRC_FORCE_ON) ? 1'b1 :
		(stop_code == pin_cfg_pkg::SRC_FORCE_OFF) ? 1'b0 : brake_pin;
	assign dir_d     = (rot_code == pin_cfg_pkg::SRC_FORCE_ON) ? 1'b1 : direction_pin;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			monitor_a_variable_address <= 12'h000;
			monitor_b_variable_address <= 12'h000;
			brake_active               <= 1'b0;
			direction_cw               <= 1'b0;
			speed_command_source       <= 2'h0;
			shared_pin_route           <= 2'h0;
			crystal_pin_repurpose      <= 1'b0;
			sleep_request              <= 1'b0;
			motor_outputs_hiz          <= 1'b0;
			watchdog_fault             <= 1'b0;
			irq                        <= 1'b0;
		end else begin
			monitor_a_variable_address <= cfg1_q[pin_cfg_pkg::MON_A_LSB +: 12];
			monitor_b_variable_address <= cfg1_q[pin_cfg_pkg::MON_B_LSB +: 12];
			brake_active               <= brake_d;
			direction_cw               <= dir_d;
			speed_command_source       <= cfg1_q[pin_cfg_pkg::SPEED_LSB +: 2];
			shared_pin_route           <= cfg2_q[pin_cfg_pkg::SHARED_LSB +: 2];
			crystal_pin_repurpose      <= cfg2_q[pin_cfg_pkg::XTAL_BIT];
			sleep_request              <= sleep_tmr.active;
			motor_outputs_hiz          <= fault_latch_q;
			watchdog_fault             <= stat_q[pin_cfg_pkg::IRQ_WD_BIT];
			irq                        <= |(stat_q & mask_q);
		end
	end

	// Bus outputs come straight from their flops.
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_reserved_zero;
		((cfg1_q & ~pin_cfg_pkg::CFG1_MASK) == 32'h0000_0000)
			&& ((cfg2_q & ~pin_cfg_pkg::CFG2_MASK) == 32'h0000_0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_mon_a_follow;
		$changed(cfg1_q[30:19]) |=> monitor_a_variable_address == $past(cfg1_q[30:19]);
	endproperty
	a_mon_a_follow: assert property (p_mon_a_follow) else $error("monitor A stale");

	property p_brake_force;
		(cfg1_q[6:5] == 2'h1) [*2] |-> brake_active;
	endproperty
	a_brake_force: assert property (p_brake_force) else $error("brake not forced");

	property p_brake_off;
		(cfg1_q[6:5] == 2'h2) [*2] |-> !brake_active;
	endproperty
	a_brake_off: assert property (p_brake_off) else $error("brake not disabled");

	property p_dir_force;
		(cfg1_q[4:3] == 2'h1) [*2] |-> direction_cw;
	endproperty
	a_dir_force: assert property (p_dir_force) else $error("rotation not forced");

	property p_speed_src;
		##1 speed_command_source == $past(cfg1_q[2:1]);
	endproperty
	a_speed_src: assert property (p_speed_src) else $error("speed source stale");

	property p_route;
		##1 (shared_pin_route == $past(cfg2_q[30:29])) && (crystal_pin_repurpose == $past(cfg2_q[27]));
	endproperty
	a_route: assert property (p_route) else $error("pin route stale");

	property p_sleep_cause;
		$rose(sleep_request) |-> $past(speed_input_low, 2);
	endproperty
	a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without low input");

	property p_wd_off;
		!wd_tmr.run |=> !wd_tmr.fire;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("expiry while disabled");

	property p_hiz;
		events[0] && cfg2_q[15] |-> ##2 motor_outputs_hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("fault did not float outputs");

	property p_tickle_restart;
		wd_tmr.run && tickle |=> ##1 !wd_tmr.fire;
	endproperty
	a_tickle_restart: assert property (p_tickle_restart) else $error("expiry after tickle");

	property p_irq;
		##1 irq == $past(|(stat_q & mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	c_write: cover property (wr_fire ##[1:4] (bvalid_q && s_axi_bready));
	c_sleep: cover property ($rose(sleep_request));
	c_expiry: cover property (events[0]);
	c_hiz: cover property ($rose(motor_outputs_hiz));

endmodule // pin_function_config_regs

// *** test/pin_function_config_regs_bench.sv ***
// Purpose: Self-checking bench for the pin function configuration registers.
// Assumes: Small timer parameters keep the run short.
// Notes:   Registers are reached over AXI4-Lite; outputs are read at an edge, before it acts.
`timescale 1ns/1ps
module pin_function_config_regs_bench;
	// Signals carry the port names so the instance connects by name.
	logic clk = 0, rstn = 0, brake_pin = 0, direction_pin = 0, speed_input_low = 0;
	logic i2c_tickle = 0, gpio_tickle_pin = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, speed_command_source, shared_pin_route, rr;
	logic [11:0] monitor_a_variable_address, monitor_b_variable_address;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic brake_active, direction_cw, crystal_pin_repurpose, sleep_request;
	logic motor_outputs_hiz, watchdog_fault, irq;
	int n_errors = 0, comparisons = 0;
	localparam logic [11:0] A1 = pin_cfg_pkg::CFG1_ADDR, A2 = pin_cfg_pkg::CFG2_ADDR;

	pin_function_config_regs #(.SLEEP_CYC_0(20), .SLEEP_CYC_1(40), .SLEEP_CYC_2(60),
		.SLEEP_CYC_3(80), .WD_CYC_0(50), .WD_CYC_1(100), .WD_CYC_2(150),
		.WD_CYC_3(200)) DUT (.*);

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// Each task leaves at least one spare edge so no strobe is driven twice in a step.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk("bvalid", 1, s_axi_bvalid);
		chk("bresp", 0, s_axi_bresp);
		if (i == 50) end_sim();
		repeat (2) @(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("rvalid", 1, s_axi_rvalid);
		if (i == 50) end_sim();
		@(posedge clk);
	endtask

	// Brake pin high and rotation pin low, so the forbid and clockwise codes differ from the pins.
	task automatic t_cfg1();
		brake_pin <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(A1, (c << 1) | (c << 5) | (c << 3) | (32'h123 << 19) | (32'h0abc << 7));
			chk("speed", c, speed_command_source);
			chk("brake", c != 2, brake_active);
			chk("cw", c == 1, direction_cw);
			chk("mon_a", 32'h0123, monitor_a_variable_address);
			chk("mon_b", 32'h0abc, monitor_b_variable_address);
		end
		wr(A1, 32'hffff_ffff);
		rd(A1);
		chk("cfg1", 32'hffff_fffe, rv);
		$display("config one test done");
	endtask

	task automatic t_cfg2();
		for (int c = 0; c < 4; c++) begin
			wr(A2, (c << 29) | (c[0] << 27));
			chk("route", c, shared_pin_route);
			chk("xtal", c[0], crystal_pin_repurpose);
		end
		wr(A2, 32'hffff_ffff);
		rd(A2);
		chk("cfg2", 32'he80f_e000, rv);
		rd(12'h100);
		chk("unmapped", 2, rr);
		chk("unmapped_data", 0, rv);
		$display("config two test done");
	endtask

	// Code 1 qualifies after 40 low cycles; the request flop adds one more.
	task automatic t_sleep();
		wr(A2, 32'h0004_0000);
		speed_input_low <= 1'b1;
		repeat (41) @(posedge clk);
		chk("sleep_early", 0, sleep_request);
		@(posedge clk);
		chk("sleep", 1, sleep_request);
		rd(12'h308);
		chk("state_sleep", 32'h4, rv);
		speed_input_low <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sleep_exit", 0, sleep_request);
		$display("sleep test done");
	endtask

	// Tickles 31 cycles apart hold off a 50-cycle period; silence then expires.
	task automatic tk(input bit g);
		repeat (3) begin
			repeat (30) @(posedge clk);
			if (g) gpio_tickle_pin <= 1'b1;
			else i2c_tickle <= 1'b1;
			@(posedge clk);
			gpio_tickle_pin <= 1'b0;
			i2c_tickle <= 1'b0;
		end
		chk("irq_early", 0, irq);
		for (int i = 0; i < 80 && !irq; i++) @(posedge clk);
		chk("irq", 1, irq);
		if (!irq) end_sim();
	endtask

	// Serial tickles with report only, then pin tickles with a latched fault.
	task automatic t_wdog();
		wr(12'h304, 32'h0000_0001);
		wr(A2, 32'h0002_0000);
		tk(1'b0);
		chk("wd_fault", 1, watchdog_fault);
		chk("hiz_report", 0, motor_outputs_hiz);
		wr(A2, 32'h0000_0000);
		wr(12'h300, 32'h0000_0001);
		chk("irq_clr", 0, irq);
		chk("wd_clr", 0, watchdog_fault);
		wr(A2, 32'h0003_8000);
		tk(1'b1);
		chk("hiz", 1, motor_outputs_hiz);
		rd(12'h308);
		chk("state", 32'h3, rv);
		wr(A2, 32'h0000_0000);
		wr(12'h300, 32'h0000_0001);
		chk("hiz_clr", 0, motor_outputs_hiz);
		$display("watchdog test done");
	endtask

	task automatic end_sim();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(A1);
		chk("cfg1_rst", 0, rv);
		t_cfg1();
		t_cfg2();
		t_sleep();
		t_wdog();
		end_sim();
	end
endmodule // pin_function_config_regs_bench
